// [rtl/mmit_top.v]
`include "mmit_regs.vh"

module mmit_top
#(
  parameter CHANNEL = 0
)
(
  // clock and reset
  input wire clk_i,
  input wire resetn_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // timer events
  output reg underflow_o,
  output reg overflow_o,
  output reg match_o,
  // pins
  output reg compare_output_pin_o,
  output reg timer_pulse_pin_o
);

  // =====================================================================
  // state
  reg [6:0] ctrl;
  reg [15:0] reload;
  reg [7:0] load;
  reg [15:0] greg;
  reg [15:0] presc;
  reg port_data;
  reg [15:0] count;
  reg [15:0] pcnt;
  reg [2:0] status;
  reg pulse_lvl;

  wire run;
  wire [2:0] mode_raw;
  wire [2:0] mode;
  wire [1:0] omode;
  wire pulse_en;
  wire tick;
  wire acc;
  wire wr;
  wire rd_cap;
  wire [2:0] next_mode;

  assign run = ctrl[`MMIT_CTRL_RUN];
  assign mode_raw = ctrl[`MMIT_CTRL_MODE_MSB:`MMIT_CTRL_MODE_LSB];
  // free running limited to low channels
  assign mode = (mode_raw == `MMIT_MODE_FREE &&
                 CHANNEL > `MMIT_LAST_FREE_CHAN) ?
                `MMIT_MODE_PERIODIC : mode_raw;
  assign omode = ctrl[`MMIT_CTRL_OMODE_MSB:`MMIT_CTRL_OMODE_LSB];
  assign pulse_en = ctrl[`MMIT_CTRL_PULSE_EN];
  assign next_mode = pwdata_i[`MMIT_CTRL_MODE_MSB:`MMIT_CTRL_MODE_LSB];

  // =====================================================================
  // apb handshake
  assign acc = psel_i & penable_i;
  assign wr = acc & pready_o & pwrite_i;
  assign rd_cap = acc & ~pready_o;

  reg mapped;
  always @*
  begin
    case (paddr_i)
      `MMIT_CTRL_OFS,
      `MMIT_RELOAD_OFS,
      `MMIT_LOAD_OFS,
      `MMIT_GREG_OFS,
      `MMIT_COUNT_OFS,
      `MMIT_STATUS_OFS,
      `MMIT_PRESC_OFS,
      `MMIT_PORT_OFS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  reg [31:0] rdata;
  always @*
  begin
    case (paddr_i)
      `MMIT_CTRL_OFS: rdata = {25'h0, ctrl};
      `MMIT_RELOAD_OFS: rdata = {16'h0000, reload};
      `MMIT_LOAD_OFS: rdata = {24'h000000, load};
      `MMIT_GREG_OFS: rdata = {16'h0000, greg};
      `MMIT_COUNT_OFS: rdata = {16'h0000, count};
      `MMIT_STATUS_OFS: rdata = {29'h0, status};
      `MMIT_PRESC_OFS: rdata = {16'h0000, presc};
      `MMIT_PORT_OFS: rdata = {31'h0, port_data};
      default: rdata = 32'h00000000;
    endcase
  end

  // one wait state, read data captured before ready
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end
    else
    begin
      pready_o <= rd_cap;
      if (rd_cap)
      begin
        pslverr_o <= ~mapped;
        prdata_o <= pwrite_i ? 32'h00000000 : rdata;
      end
      else
      begin
        pslverr_o <= 1'b0;
      end
    end
  end

  // =====================================================================
  // prescaler, count source tick
  // tick only while running
  assign tick = run && (pcnt == presc);

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pcnt <= 16'h0000;
    end
    else if (!run || tick)
    begin
      pcnt <= 16'h0000;
    end
    else
    begin
      pcnt <= pcnt + 16'h0001;
    end
  end

  // =====================================================================
  // counter events
  reg ev_unf;
  reg ev_ovf;
  reg ev_match;
  reg [15:0] next_count;

  always @*
  begin
    ev_unf = 1'b0;
    ev_ovf = 1'b0;
    ev_match = 1'b0;
    next_count = count;
    if (tick)
    begin
      case (mode)
        `MMIT_MODE_DOWN:
        begin
          if (count == 16'h0000)
          begin
            ev_unf = 1'b1;
            next_count = reload;
          end
          else
          begin
            next_count = count - 16'h0001;
          end
        end
        `MMIT_MODE_INTERVAL:
        begin
          if (count[7:0] == `MMIT_MAX8)
          begin
            ev_ovf = 1'b1;
            next_count = 16'h0000;
          end
          else
          begin
            next_count = {8'h00, count[7:0] + 8'h01};
          end
        end
        `MMIT_MODE_AUTOLOAD:
        begin
          if (count[7:0] == `MMIT_MAX8)
          begin
            ev_ovf = 1'b1;
            next_count = {8'h00, load};
          end
          else
          begin
            next_count = {8'h00, count[7:0] + 8'h01};
          end
        end
        `MMIT_MODE_ZEROSTART,
        `MMIT_MODE_FREE:
        begin
          ev_ovf = (count == `MMIT_MAX16);
          next_count = count + 16'h0001;
        end
        `MMIT_MODE_PERIODIC:
        begin
          if (count == greg)
          begin
            ev_match = 1'b1;
            next_count = 16'h0000;
          end
          else
          begin
            next_count = count + 16'h0001;
          end
        end
        default:
        begin
          next_count = count;
        end
      endcase
    end
  end

  // =====================================================================
  // registers and counter
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl <= `MMIT_CTRL_RST;
      reload <= `MMIT_RELOAD_RST;
      load <= `MMIT_LOAD_RST;
      greg <= `MMIT_GREG_RST;
      presc <= `MMIT_PRESC_RST;
      port_data <= 1'b0;
      count <= 16'h0000;
    end
    else
    begin
      count <= next_count;
      if (wr)
      begin
        case (paddr_i)
          `MMIT_CTRL_OFS:
          begin
            ctrl <= pwdata_i[6:0];
            if (next_mode != mode_raw)
            begin
              case (next_mode)
                `MMIT_MODE_DOWN: count <= reload;
                `MMIT_MODE_AUTOLOAD: count <= {8'h00, load};
                default: count <= 16'h0000;
              endcase
            end
          end
          `MMIT_RELOAD_OFS: reload <= pwdata_i[15:0];
          `MMIT_LOAD_OFS: load <= pwdata_i[7:0];
          `MMIT_GREG_OFS: greg <= pwdata_i[15:0];
          `MMIT_COUNT_OFS: count <= pwdata_i[15:0];
          `MMIT_PRESC_OFS: presc <= pwdata_i[15:0];
          `MMIT_PORT_OFS: port_data <= pwdata_i[0];
          default: count <= next_count;
        endcase
      end
    end
  end

  // =====================================================================
  // sticky status, set wins over clear
  wire [2:0] set_bits;
  wire [2:0] clr_bits;
  assign set_bits = {ev_match, ev_ovf, ev_unf};
  assign clr_bits = (wr && paddr_i == `MMIT_STATUS_OFS) ?
                    pwdata_i[2:0] : 3'h0;

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      status <= 3'h0;
      underflow_o <= 1'b0;
      overflow_o <= 1'b0;
      match_o <= 1'b0;
    end
    else
    begin
      status <= (status & ~clr_bits) | set_bits;
      underflow_o <= ev_unf;
      overflow_o <= ev_ovf;
      match_o <= ev_match;
    end
  end

  // =====================================================================
  // compare output pin
  wire omode_wr;
  assign omode_wr = wr && (paddr_i == `MMIT_CTRL_OFS) &&
    (pwdata_i[`MMIT_CTRL_OMODE_MSB:`MMIT_CTRL_OMODE_LSB] != omode);

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      compare_output_pin_o <= 1'b0;
    end
    else if (omode_wr &&
             pwdata_i[`MMIT_CTRL_OMODE_MSB:`MMIT_CTRL_OMODE_LSB] !=
             `MMIT_OMODE_HOLD)
    begin
      compare_output_pin_o <= 1'b0;
    end
    else if (ev_match)
    begin
      case (omode)
        `MMIT_OMODE_HOLD: compare_output_pin_o <= compare_output_pin_o;
        `MMIT_OMODE_LOW: compare_output_pin_o <= 1'b0;
        `MMIT_OMODE_HIGH: compare_output_pin_o <= 1'b1;
        `MMIT_OMODE_TOGGLE: compare_output_pin_o <= ~compare_output_pin_o;
        default: compare_output_pin_o <= compare_output_pin_o;
      endcase
    end
  end

  // =====================================================================
  // pulse pin
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pulse_lvl <= 1'b0;
      timer_pulse_pin_o <= 1'b0;
    end
    else
    begin
      if (ev_unf | ev_ovf)
      begin
        pulse_lvl <= ~pulse_lvl;
      end
      timer_pulse_pin_o <= pulse_en ? pulse_lvl : port_data;
    end
  end

endmodule

// [rtl/mmit_regs.vh]
`ifndef MMIT_REGS_VH
`define MMIT_REGS_VH

// =====================================================================
// register byte offsets
`define MMIT_CTRL_OFS 8'h00
`define MMIT_RELOAD_OFS 8'h04
`define MMIT_LOAD_OFS 8'h08
`define MMIT_GREG_OFS 8'h0c
`define MMIT_COUNT_OFS 8'h10
`define MMIT_STATUS_OFS 8'h14
`define MMIT_PRESC_OFS 8'h18
`define MMIT_PORT_OFS 8'h1c

// =====================================================================
// control fields
`define MMIT_CTRL_RUN 0
`define MMIT_CTRL_MODE_LSB 1
`define MMIT_CTRL_MODE_MSB 3
`define MMIT_CTRL_OMODE_LSB 4
`define MMIT_CTRL_OMODE_MSB 5
`define MMIT_CTRL_PULSE_EN 6

// =====================================================================
// count modes
`define MMIT_MODE_DOWN 3'h0
`define MMIT_MODE_INTERVAL 3'h1
`define MMIT_MODE_AUTOLOAD 3'h2
`define MMIT_MODE_ZEROSTART 3'h3
`define MMIT_MODE_FREE 3'h4
`define MMIT_MODE_PERIODIC 3'h5

// =====================================================================
// compare output modes
`define MMIT_OMODE_HOLD 2'h0
`define MMIT_OMODE_LOW 2'h1
`define MMIT_OMODE_HIGH 2'h2
`define MMIT_OMODE_TOGGLE 2'h3

// =====================================================================
// status bits
`define MMIT_ST_UNDERFLOW 0
`define MMIT_ST_OVERFLOW 1
`define MMIT_ST_MATCH 2

// =====================================================================
// reset values and limits
`define MMIT_CTRL_RST 7'h00
`define MMIT_RELOAD_RST 16'hffff
`define MMIT_LOAD_RST 8'h00
`define MMIT_GREG_RST 16'hffff
`define MMIT_PRESC_RST 16'h0000
`define MMIT_MAX8 8'hff
`define MMIT_MAX16 16'hffff
`define MMIT_LAST_FREE_CHAN 4
`endif

// [verif/mmit_top_assertions.sv]
module mmit_chk
#(
  parameter CHANNEL = 0
)
(
  // clock and reset
  input wire clk_i,
  input wire resetn_i,
  // apb
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  // events and pins
  input wire underflow_o,
  input wire overflow_o,
  input wire match_o,
  input wire compare_output_pin_o,
  input wire timer_pulse_pin_o
);
  // ==========================================
  // shadow of control and port data
  reg [6:0] ctrl;
  reg port;
  wire wr = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
  wire [2:0] mode = ctrl[3:1];
  wire [1:0] om = ctrl[5:4];
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl <= 7'h00;
      port <= 1'b0;
    end
    else if (wr && paddr_i == 8'h00)
      ctrl <= pwdata_i[6:0];
    else if (wr && paddr_i == 8'h1c)
      port <= pwdata_i[0];
  end
  // ==========================================
  // properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  AST_READY_WAIT: assert property (psel_i && penable_i && !pready_o
    |=> pready_o) else $error("access not answered after one wait");
  AST_STOP_QUIET: assert property (!ctrl[0] && !$past(ctrl[0])
    |-> !(underflow_o || overflow_o || match_o)) else $error("event stopped");
  AST_UNF_MODE: assert property (underflow_o
    |-> $past(mode) == 3'h0) else $error("underflow outside down mode");
  AST_OVF_MODE: assert property (overflow_o |-> $past(mode) inside
    {3'h1, 3'h2, 3'h3} || $past(mode) == 3'h4 && CHANNEL <= 4)
    else $error("overflow in wrong mode");
  AST_MATCH_MODE: assert property (match_o |-> $past(mode) == 3'h5
    || $past(mode) == 3'h4 && CHANNEL > 4) else $error("match in wrong mode");
  AST_HOLD_PIN: assert property (om == 2'h0 && $past(om, 2) == 2'h0
    |-> $stable(compare_output_pin_o)) else $error("pin moved in hold");
  AST_PIN_HIGH: assert property (match_o && om == 2'h2
    && $past(om) == 2'h2 |-> ##[0:1] compare_output_pin_o)
    else $error("pin not driven high");
  AST_PORT_PIN: assert property (!ctrl[6]
    |=> timer_pulse_pin_o == $past(port)) else $error("pulse pin not port");
endmodule

bind mmit_top mmit_chk #(.CHANNEL(CHANNEL)) i_chk (.clk_i(clk_i),
  .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .underflow_o(underflow_o), .overflow_o(overflow_o), .match_o(match_o),
  .compare_output_pin_o(compare_output_pin_o),
  .timer_pulse_pin_o(timer_pulse_pin_o));

// [verif/multi_mode_interval_timer_test.sv]
module multi_mode_interval_timer_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, c;
  logic pready, perr, err, unf, ovf, mat, cmp, pls, v;
  wire [2:0] ev = {mat, ovf, unf};
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int k;
  int rv[8] = '{0, 'hffff, 0, 'hffff, 0, 0, 0, 0};
  int ml[8] = '{2, 1, 0, 3, 0, 4, 0, 5};
  int mc[8] = '{'hf0, 0, 3, 0, 3, 0, 3, 0};
  int pm[4] = '{0, 1, 2, 5};
  int ps[4] = '{0, 1, 1, 2};
  int pp[4] = '{4, 256, 16, 6};
  int om[5] = '{2, 0, 3, 3, 1};
  int pv[5] = '{1, 1, 1, 1, 0};
  mmit_top i_dut (.clk_i(clk), .resetn_i(rstn), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .underflow_o(unf), .overflow_o(ovf), .match_o(mat),
    .compare_output_pin_o(cmp), .timer_pulse_pin_o(pls));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  // ==========================================
  // tasks
  task chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("register", rd, e);
  endtask
  task ctl(input logic [2:0] m, input logic [1:0] o, input logic r, p);
    apb(1'b1, 8'h00, {25'h0, p, o, m, r});
  endtask
  task waitev(input int s);
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ev[s] !== 1'b1 && k < 400);
    chk("event seen", ev[s], 1'b1);
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end
  // ==========================================
  // tests
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++)
      rdc(8'(i * 4), rv[i]);
    apb(1'b1, 8'h20, 32'h5);
    chk("slverr", err, 1);
    rdc(8'h08, 0);
    $display("test reset done");
    apb(1'b1, 8'h04, 32'h3);
    apb(1'b1, 8'h08, 32'hf0);
    apb(1'b1, 8'h0c, 32'h5);
    for (int i = 0; i < 8; i++)
    begin
      ctl(3'(ml[i]), 2'h0, 1'b0, 1'b0);
      rdc(8'h10, mc[i]);
    end
    for (int i = 0; i < 4; i++)
    begin
      ctl(3'(pm[i]), 2'h0, 1'b1, 1'b0);
      waitev(ps[i]);
      waitev(ps[i]);
      chk("period", k, pp[i]);
      ctl(3'(pm[i]), 2'h0, 1'b0, 1'b0);
      rdc(8'h14, 1 << ps[i]);
      apb(1'b1, 8'h14, 32'h7);
      rdc(8'h14, 0);
    end
    for (int m = 3; m < 5; m++)
    begin
      ctl(3'(m), 2'h0, 1'b0, 1'b0);
      apb(1'b1, 8'h10, 32'hfff0);
      ctl(3'(m), 2'h0, 1'b1, 1'b0);
      waitev(1);
      chk("wrap", k, 16);
    end
    $display("test modes done");
    for (int i = 0; i < 5; i++)
    begin
      ctl(3'h5, 2'(om[i]), 1'b0, 1'b0);
      apb(1'b1, 8'h10, 32'h0);
      ctl(3'h5, 2'(om[i]), 1'b1, 1'b0);
      waitev(2);
      repeat (2) @(posedge clk);
      chk("compare pin", cmp, pv[i]);
    end
    ctl(3'h0, 2'h0, 1'b0, 1'b0);
    apb(1'b1, 8'h1c, 32'h1);
    @(posedge clk);
    chk("port pin", pls, 1);
    ctl(3'h0, 2'h0, 1'b1, 1'b1);
    waitev(0);
    repeat (2) @(posedge clk);
    v = pls;
    waitev(0);
    repeat (2) @(posedge clk);
    chk("pulse pin", pls, !v);
    ctl(3'h0, 2'h0, 1'b0, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    c = rd;
    repeat (9) @(posedge clk);
    rdc(8'h10, c);
    $display("test pins done");
    finish_test();
  end
endmodule
